// ---- core/tcc_host.sv ----
// CPU-side controller: AHB-Lite slave that issues byte accesses to the timer core.
`timescale 1ns/1ps
module tcc_host
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    tcc_link_if.host         link,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hsel,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output      logic [31:0] hrdata,
    output      logic        hreadyout,
    output      logic        hresp,
    output      logic        irq
);
    import tcc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    logic        ph_r;
    logic        ph_wr_r;
    logic [3:0]  ph_idx_r;
    logic [31:0] hrdata_r;
    logic [2:0]  l_addr_r;
    logic        l_wr_r;
    logic        l_rd_r;
    logic [7:0]  l_wdata_r;
    logic        l_ovf_ack_r;
    logic        l_cap_ack_r;
    logic [7:0]  irq_en_r;
    logic [1:0]  acks;
    logic        direct;

    assign hresp     = 1'b0;
    assign hreadyout = 1'b1;
    assign hrdata    = hrdata_r;

    // Address phase capture; every access answers with zero wait states.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ph_r     <= 1'b0;
            ph_wr_r  <= 1'b0;
            ph_idx_r <= 4'h0;
        end
        else
        begin
            ph_r     <= hsel && hready && htrans[1];
            ph_wr_r  <= hwrite;
            ph_idx_r <= haddr[5:2];
        end
    end

    // Core reads are issued from the address phase.
    assign direct = hsel && hready && htrans[1] && !hwrite && haddr[5:2] < IDX_FLAGS + 4'h1;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            l_addr_r  <= 3'h0;
            l_wr_r    <= 1'b0;
            l_rd_r    <= 1'b0;
            l_wdata_r <= 8'h00;
        end
        else if (direct)
        begin
            l_addr_r <= haddr[4:2];
            l_rd_r   <= 1'b1;
            l_wr_r   <= 1'b0;
        end
        else if (ph_r && ph_wr_r && (ph_idx_r <= IDX_FLAGS || ph_idx_r == IDX_CMP_CTRL))
        begin
            l_addr_r  <= (ph_idx_r == IDX_CMP_CTRL) ? LA_CMP_CTRL : ph_idx_r[2:0];
            l_wr_r    <= 1'b1;
            l_rd_r    <= 1'b0;
            l_wdata_r <= hwdata[7:0];
        end
        else
        begin
            l_wr_r <= 1'b0;
            l_rd_r <= 1'b0;
        end
    end

    assign link.addr  = l_addr_r;
    assign link.wr    = l_wr_r;
    assign link.rd    = l_rd_r;
    assign link.wdata = l_wdata_r;

    // Interrupt acknowledge pulses from the command register.
    assign acks = (ph_r && ph_wr_r && ph_idx_r == IDX_LINK_CMD) ? hwdata[1:0] : 2'b00;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            l_ovf_ack_r <= 1'b0;
            l_cap_ack_r <= 1'b0;
            irq_en_r    <= 8'h00;
        end
        else
        begin
            l_ovf_ack_r <= acks[0];
            l_cap_ack_r <= acks[1];
            if (ph_r && ph_wr_r && ph_idx_r == IDX_IRQ_EN)
                irq_en_r <= hwdata[7:0];
        end
    end

    assign link.ovf_ack = l_ovf_ack_r;
    assign link.cap_ack = l_cap_ack_r;
    assign irq = (link.ovf_irq && irq_en_r[OVF_POS]) || (link.cap_irq && irq_en_r[CAPF_POS]);

    // Link read data stands in the data phase.
    always_comb
    begin
        hrdata_r = 32'h0000_0000;
        if (ph_r && !ph_wr_r)
        begin
            if (ph_idx_r <= IDX_FLAGS)
                hrdata_r = {24'h00_0000, link.rdata};
            else if (ph_idx_r == IDX_IRQ_EN)
                hrdata_r = {24'h00_0000, irq_en_r};
            else if (ph_idx_r == IDX_LINK_STS)
                hrdata_r = {30'h0000_0000, irq, 1'b0};
        end
    end

endmodule : tcc_host

// ---- core/tcc_link_if.sv ----
// Interface joining the timer core and its CPU-side controller over a byte bus.
`timescale 1ns/1ps
interface tcc_link_if;
    logic [2:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       ovf_ack;
    logic       cap_ack;
    logic       ovf_irq;
    logic       cap_irq;

    modport dev
    (
        input  addr, wr, rd, wdata, ovf_ack, cap_ack,
        output rdata, ovf_irq, cap_irq
    );
    modport host
    (
        output addr, wr, rd, wdata, ovf_ack, cap_ack,
        input  rdata, ovf_irq, cap_irq
    );
endinterface : tcc_link_if

// ---- core/tcc_pkg.sv ----
// Package with register indices, field positions, reset values and modes for the timer core.
package tcc_pkg;

    // Register indices; byte address is four times the index.
    localparam logic [3:0] IDX_CNT_LO   = 4'h0;
    localparam logic [3:0] IDX_CNT_HI   = 4'h1;
    localparam logic [3:0] IDX_CAP_LO   = 4'h2;
    localparam logic [3:0] IDX_CAP_HI   = 4'h3;
    localparam logic [3:0] IDX_CTRL_A   = 4'h4;
    localparam logic [3:0] IDX_CTRL_B   = 4'h5;
    localparam logic [3:0] IDX_FLAGS    = 4'h6;
    localparam logic [3:0] IDX_IRQ_EN   = 4'h7;
    localparam logic [3:0] IDX_CMP_CTRL = 4'h8;
    localparam logic [3:0] IDX_LINK_CMD = 4'h9;
    localparam logic [3:0] IDX_LINK_DAT = 4'hA;
    localparam logic [3:0] IDX_LINK_STS = 4'hB;
    localparam logic [3:0] IDX_LINK_PIN = 4'hC;

    // Control register A: waveform mode low bits.
    localparam int WGM_LO_POS = 0;
    // Control register B fields.
    localparam int CS_POS     = 0;
    localparam int WGM_HI_POS = 3;
    localparam int EDGE_POS   = 6;
    localparam int FILT_POS   = 7;
    // Flag and enable bit positions.
    localparam int OVF_POS    = 0;
    localparam int CAPF_POS   = 5;
    // Comparator control: capture source select bit.
    localparam int ACS_POS    = 2;

    localparam logic [7:0]  CTRL_RST   = 8'h00;
    localparam logic [15:0] CNT_RST    = 16'h0000;
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [15:0] CNT_MAX    = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT   = 16'h00FF;
    localparam logic [15:0] TOP_9BIT   = 16'h01FF;
    localparam logic [15:0] TOP_10BIT  = 16'h03FF;
    localparam int          FILT_LEN   = 4;

    // Waveform modes; modes 8, 10, 12 and 14 use the capture register as top.
    localparam logic [3:0] WGM_NORMAL   = 4'h0;
    localparam logic [3:0] WGM_PC8      = 4'h1;
    localparam logic [3:0] WGM_PC9      = 4'h2;
    localparam logic [3:0] WGM_PC10     = 4'h3;
    localparam logic [3:0] WGM_CTC_OCR  = 4'h4;
    localparam logic [3:0] WGM_FAST8    = 4'h5;
    localparam logic [3:0] WGM_FAST9    = 4'h6;
    localparam logic [3:0] WGM_FAST10   = 4'h7;
    localparam logic [3:0] WGM_PFC_CAP  = 4'h8;
    localparam logic [3:0] WGM_PC_CAP   = 4'hA;
    localparam logic [3:0] WGM_CTC_CAP  = 4'hC;
    localparam logic [3:0] WGM_FAST_CAP = 4'hE;

    // Link byte bus register addresses.
    localparam logic [2:0] LA_CNT_LO   = 3'h0;
    localparam logic [2:0] LA_CNT_HI   = 3'h1;
    localparam logic [2:0] LA_CAP_LO   = 3'h2;
    localparam logic [2:0] LA_CAP_HI   = 3'h3;
    localparam logic [2:0] LA_CTRL_A   = 3'h4;
    localparam logic [2:0] LA_CTRL_B   = 3'h5;
    localparam logic [2:0] LA_FLAGS    = 3'h6;
    localparam logic [2:0] LA_CMP_CTRL = 3'h7;

    // Host link command word fields.
    localparam int CMD_ADDR_POS = 0;
    localparam int CMD_WR_POS   = 8;
    localparam int CMD_ACK_POS  = 9;
    localparam int STS_BUSY_POS = 0;
    localparam int STS_IRQ_POS  = 1;

    typedef enum logic [2:0]
    {
        HS_IDLE = 3'b001,
        HS_ADDR = 3'b010,
        HS_DATA = 3'b100
    } tcc_hstate_t;

endpackage : tcc_pkg

// ---- core/tcc_timer.sv ----
// Timer core with 16-bit up/down counter, shared high-byte holding register and input capture.
// Overview of operation
// - Shared high byte may be written once.
// - Clock select zero halts the counter.
// - Sixteen-bit up/down counter with clear, top, bottom.
// - Upper location reaches holding register; lower transfers.
// - Each tick clears, increments or decrements per mode.
// - Counter accessible with or without timer tick.
// - CPU write beats clear and count.
// - Four-bit waveform field sets count sequence.
// - Overflow flag set per mode, requests interrupt.
// - Qualified edge copies counter, sets capture flag.
// - Enabled capture flag interrupts; cleared by ack/one.
// - Capture low read loads holding register.
// - Capture writable only in capture-top modes.
// - Comparator select replaces pin on instance one.
// - Software clears capture flag after source change.
// - Filter output changes after four equal samples.
// - Filter enable adds four system cycles delay.
// - Capture inputs active except capture-top modes.
// - Port bit drive of pin triggers capture.
// - New capture overwrites unread capture register.
// - Avoid capture while top value changes.
// - Write upper byte first; read lower first.
// - Bottom is 0x0000, maximum is 0xFFFF.
//
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module tcc_timer
#(
    parameter int          PRESCALE     = 8,
    parameter bit          HAS_CMP_SRC  = 1'b1
)
(
    input  wire logic      clk_sys,
    input  wire logic      rst,
    tcc_link_if.dev        link,
    input  wire logic      capture_input_pin,
    input  wire logic      comparator_output,
    input  wire logic      ext_clk_pin,
    output      logic [15:0] count_value,
    output      logic      at_top,
    output      logic      at_bottom
);
    import tcc_pkg::*;

    if (PRESCALE < 2 || PRESCALE > 1024)
    begin : g_bad_prescale
        $error("PRESCALE out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [15:0] cnt_r;
    logic [15:0] cap_r;
    logic [7:0]  hold_r;
    logic [7:0]  ctrl_a_r;
    logic [7:0]  ctrl_b_r;
    logic [7:0]  cmp_ctrl_r;
    logic        ovf_r;
    logic        capf_r;
    logic        up_r;
    logic [9:0]  pre_r;
    logic [1:0]  pin_s_r;
    logic [1:0]  cmp_s_r;
    logic [1:0]  ext_s_r;
    logic        ext_d_r;
    logic [FILT_LEN-2:0] filt_sh_r;
    logic        filt_out_r;
    logic        edge_d_r;
    logic [2:0]  cs;
    logic [3:0]  wgm;
    logic        tick;
    logic        pre_tick;
    logic [15:0] top;
    logic        cap_top;
    logic        src;
    logic        filt_in;
    logic        cap_evt;
    logic        ovf_evt;
    logic        wr_cnt;
    logic        ctc_mode;
    logic        dual_slope;

    assign cs      = ctrl_b_r[CS_POS +: 3];
    assign wgm     = {ctrl_b_r[WGM_HI_POS +: 2], ctrl_a_r[WGM_LO_POS +: 2]};
    assign wr_cnt  = link.wr && (link.addr == LA_CNT_LO);

    ////////////////////////////////////////////////////////////////////////////
    // Timer tick source: system clock, undivided or prescaled, or synchronised external pin.
    assign pre_tick = (pre_r == 10'(PRESCALE - 1));

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pre_r <= 10'h000;
        end
        else
        begin
            pre_r <= pre_tick ? 10'h000 : pre_r + 10'h001;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ext_s_r <= 2'b00;
            ext_d_r <= 1'b0;
        end
        else
        begin
            ext_s_r <= {ext_s_r[0], ext_clk_pin};
            ext_d_r <= ext_s_r[1];
        end
    end

    always_comb
    begin
        case (cs)
            3'h0:    tick = 1'b0;
            3'h1:    tick = 1'b1;
            3'h2:    tick = pre_tick;
            3'h6:    tick = ext_d_r && !ext_s_r[1];
            3'h7:    tick = !ext_d_r && ext_s_r[1];
            default: tick = pre_tick;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Waveform mode decode: top value and sequence kind.
    assign cap_top = (wgm == WGM_PFC_CAP) || (wgm == WGM_PC_CAP)
                  || (wgm == WGM_CTC_CAP) || (wgm == WGM_FAST_CAP);
    assign ctc_mode   = (wgm == WGM_CTC_CAP) || (wgm == WGM_CTC_OCR);
    assign dual_slope = (wgm == WGM_PC8) || (wgm == WGM_PC9) || (wgm == WGM_PC10)
                     || (wgm == WGM_PFC_CAP) || (wgm == WGM_PC_CAP);

    always_comb
    begin
        case (wgm)
            WGM_PC8, WGM_FAST8:   top = TOP_8BIT;
            WGM_PC9, WGM_FAST9:   top = TOP_9BIT;
            WGM_PC10, WGM_FAST10: top = TOP_10BIT;
            WGM_PFC_CAP, WGM_PC_CAP, WGM_CTC_CAP, WGM_FAST_CAP: top = cap_r;
            default:              top = CNT_MAX;
        endcase
    end

    assign at_top      = (cnt_r == CNT_MAX);
    assign at_bottom   = (cnt_r == CNT_BOTTOM);
    assign count_value = cnt_r;

    ////////////////////////////////////////////////////////////////////////////
    // Counter with direction; CPU write overrides count and clear.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cnt_r <= CNT_RST;
            up_r  <= 1'b1;
        end
        else if (wr_cnt)
        begin
            cnt_r <= {hold_r, link.wdata};
        end
        else if (tick)
        begin
            if (dual_slope)
            begin
                if (up_r && cnt_r >= top)
                begin
                    up_r  <= 1'b0;
                    cnt_r <= cnt_r - 16'h0001;
                end
                else if (!up_r && cnt_r == CNT_BOTTOM)
                begin
                    up_r  <= 1'b1;
                    cnt_r <= cnt_r + 16'h0001;
                end
                else
                begin
                    cnt_r <= up_r ? cnt_r + 16'h0001 : cnt_r - 16'h0001;
                end
            end
            else
            begin
                up_r  <= 1'b1;
                cnt_r <= (cnt_r == top) ? CNT_BOTTOM : cnt_r + 16'h0001;
            end
        end
    end

    always_comb
    begin
        if (dual_slope)
        begin
            ovf_evt = tick && !up_r && cnt_r == CNT_BOTTOM;
        end
        else if (ctc_mode || wgm == WGM_NORMAL)
        begin
            ovf_evt = tick && cnt_r == CNT_MAX;
        end
        else
        begin
            ovf_evt = tick && cnt_r == top;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Capture source, synchroniser, noise filter and edge detector.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pin_s_r <= 2'b00;
            cmp_s_r <= 2'b00;
        end
        else
        begin
            pin_s_r <= {pin_s_r[0], capture_input_pin};
            cmp_s_r <= {cmp_s_r[0], comparator_output};
        end
    end

    assign src = (HAS_CMP_SRC && cmp_ctrl_r[ACS_POS]) ? cmp_s_r[1] : pin_s_r[1];

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            filt_sh_r  <= '0;
            filt_out_r <= 1'b0;
        end
        else if (!cap_top)
        begin
            filt_sh_r <= {filt_sh_r[FILT_LEN-3:0], src};
            if (&{filt_sh_r, src} || ~|{filt_sh_r, src})
            begin
                filt_out_r <= src;
            end
        end
    end

    assign filt_in = ctrl_b_r[FILT_POS] ? filt_out_r : src;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            edge_d_r <= 1'b0;
        end
        else if (!cap_top)
        begin
            edge_d_r <= filt_in;
        end
    end

    assign cap_evt = !cap_top && (ctrl_b_r[EDGE_POS] ? (filt_in && !edge_d_r)
                                                     : (!filt_in && edge_d_r));

    ////////////////////////////////////////////////////////////////////////////
    // Capture register, holding register and control registers.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cap_r <= CNT_RST;
        end
        else if (cap_evt)
        begin
            cap_r <= cnt_r;
        end
        else if (link.wr && link.addr == LA_CAP_LO && cap_top)
        begin
            cap_r <= {hold_r, link.wdata};
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            hold_r <= 8'h00;
        end
        else if (link.wr && (link.addr == LA_CNT_HI || link.addr == LA_CAP_HI))
        begin
            hold_r <= link.wdata;
        end
        else if (link.rd && link.addr == LA_CNT_LO)
        begin
            hold_r <= cnt_r[15:8];
        end
        else if (link.rd && link.addr == LA_CAP_LO)
        begin
            hold_r <= cap_r[15:8];
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ctrl_a_r   <= CTRL_RST;
            ctrl_b_r   <= CTRL_RST;
            cmp_ctrl_r <= CTRL_RST;
        end
        else if (link.wr)
        begin
            if (link.addr == LA_CTRL_A)   ctrl_a_r   <= link.wdata;
            if (link.addr == LA_CTRL_B)   ctrl_b_r   <= link.wdata;
            if (link.addr == LA_CMP_CTRL) cmp_ctrl_r <= link.wdata;
        end
    end

    // Flags: a new event wins over a clear in the same cycle.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ovf_r  <= 1'b0;
            capf_r <= 1'b0;
        end
        else
        begin
            if (ovf_evt)
                ovf_r <= 1'b1;
            else if (link.ovf_ack || (link.wr && link.addr == LA_FLAGS && link.wdata[OVF_POS]))
                ovf_r <= 1'b0;
            if (cap_evt)
                capf_r <= 1'b1;
            else if (link.cap_ack || (link.wr && link.addr == LA_FLAGS && link.wdata[CAPF_POS]))
                capf_r <= 1'b0;
        end
    end

    assign link.ovf_irq = ovf_r;
    assign link.cap_irq = capf_r;

    always_comb
    begin
        case (link.addr)
            LA_CNT_LO:   link.rdata = cnt_r[7:0];
            LA_CAP_LO:   link.rdata = cap_r[7:0];
            LA_CNT_HI,
            LA_CAP_HI:   link.rdata = hold_r;
            LA_CTRL_A:   link.rdata = ctrl_a_r;
            LA_CTRL_B:   link.rdata = ctrl_b_r;
            LA_FLAGS:    link.rdata = {2'b00, capf_r, 4'h0, ovf_r};
            default:     link.rdata = cmp_ctrl_r;
        endcase
    end

endmodule : tcc_timer

// ---- test/tcc_link_sva.sv ----
// Checker for the byte link between the timer core and its controller.
`timescale 1ns/1ps
module tcc_link_sva
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic [2:0]  addr,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [7:0]  wdata,
    input wire logic [7:0]  rdata,
    input wire logic        ovf_ack,
    input wire logic        cap_ack,
    input wire logic        ovf_irq,
    input wire logic        cap_irq,
    input wire logic [15:0] count_value,
    input wire logic        at_top,
    input wire logic        at_bottom
);
    import tcc_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [7:0] hold_r;
    logic       hold_ok_r;
    logic [2:0] cs_r;
    ////////////////////////////////////////////////////////////////////////////
    // Mirror of the holding byte; unknown after a capture low read.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            hold_r    <= 8'h00;
            hold_ok_r <= 1'b1;
        end
        else if (wr && (addr == LA_CNT_HI || addr == LA_CAP_HI))
        begin
            hold_r    <= wdata;
            hold_ok_r <= 1'b1;
        end
        else if (rd && addr == LA_CNT_LO)
        begin
            hold_r    <= count_value[15:8];
            hold_ok_r <= 1'b1;
        end
        else if (rd && addr == LA_CAP_LO)
            hold_ok_r <= 1'b0;
    end
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            cs_r <= 3'h0;
        else if (wr && addr == LA_CTRL_B)
            cs_r <= wdata[2:0];
    end
    ////////////////////////////////////////////////////////////////////////////
    a_top_level: assert property (at_top == (count_value == CNT_MAX))
        else $error("top level wrong");
    a_bottom_level: assert property (at_bottom == (count_value == CNT_BOTTOM))
        else $error("bottom level wrong");
    a_lo_read: assert property (rd && addr == LA_CNT_LO |-> rdata == count_value[7:0])
        else $error("low byte read wrong");
    a_hold_read: assert property (rd && (addr == LA_CNT_HI || addr == LA_CAP_HI) && hold_ok_r
        |-> rdata == hold_r)
        else $error("holding byte read wrong");
    a_cnt_write: assert property (wr && addr == LA_CNT_LO
        |=> count_value == {$past(hold_r), $past(wdata)})
        else $error("counter write not taken whole");
    a_halt_cs0: assert property (cs_r == 3'h0 && !(wr && addr == LA_CNT_LO)
        |=> $stable(count_value))
        else $error("counter moved while halted");
    a_cap_ack: assert property (cap_ack |=> !cap_irq)
        else $error("capture flag kept after service");
    a_ovf_ack: assert property (ovf_ack |=> !ovf_irq)
        else $error("overflow flag kept after service");
    a_flag_w1c: assert property (wr && addr == LA_FLAGS && wdata[CAPF_POS] |=> !cap_irq)
        else $error("capture flag kept after write of one");
    c_cap: cover property ($rose(cap_irq));
    c_ovf: cover property ($rose(ovf_irq));
    c_cnt_wr: cover property (wr && addr == LA_CNT_LO);
endmodule : tcc_link_sva

// ---- test/timer16_counter_input_capture_tb.sv ----
// Testbench joining controller and timer core, driven over AHB-Lite.
`timescale 1ns/1ps
module timer16_counter_input_capture_tb;
    import tcc_pkg::*;
    typedef struct packed {logic [15:0] val; logic top; logic bot;} tcc_row_t;
    logic        clk_sys, rst, hwrite, hsel, hreadyout, hresp, irq;
    logic        capture_input_pin, comparator_output, ext_clk_pin, at_top, at_bottom;
    logic [31:0] haddr, hwdata, hrdata, rd_q;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [15:0] count_value;
    int          err_total, n_compared, cap_lat, lat0;
    tcc_row_t    rows [4] = '{'{16'h01FF, 1'b0, 1'b0}, '{16'hFFFF, 1'b1, 1'b0},
                             '{16'h0000, 1'b0, 1'b1}, '{16'hA55A, 1'b0, 1'b0}};
    tcc_link_if tcc_link_if_i ();
    tcc_timer #(.PRESCALE(8), .HAS_CMP_SRC(1'b1)) tcc_timer_i (.clk_sys(clk_sys), .rst(rst),
        .link(tcc_link_if_i), .capture_input_pin(capture_input_pin),
        .comparator_output(comparator_output), .ext_clk_pin(ext_clk_pin),
        .count_value(count_value), .at_top(at_top), .at_bottom(at_bottom));
    tcc_host tcc_host_i (.clk_sys(clk_sys), .rst(rst), .link(tcc_link_if_i), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hsel(hsel), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
    tcc_link_sva tcc_link_sva_i (.clk_sys(clk_sys), .rst(rst), .addr(tcc_link_if_i.addr),
        .wr(tcc_link_if_i.wr), .rd(tcc_link_if_i.rd), .wdata(tcc_link_if_i.wdata),
        .rdata(tcc_link_if_i.rdata), .ovf_ack(tcc_link_if_i.ovf_ack),
        .cap_ack(tcc_link_if_i.cap_ack), .ovf_irq(tcc_link_if_i.ovf_irq),
        .cap_irq(tcc_link_if_i.cap_irq), .count_value(count_value), .at_top(at_top),
        .at_bottom(at_bottom));
    always #10 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_ready;
        for (int n = 0; n < 50; n++)
        begin
            @(posedge clk_sys);
            if (hreadyout === 1'b1)
                return;
        end
        err_total++;
        complete_run();
    endtask : wait_ready
    // Single word transfer; read data lands in rd_q.
    task automatic xfer(input logic w, input logic [3:0] idx, input logic [31:0] wd);
        haddr  <= {26'h000_0000, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd_q = hrdata;
    endtask : xfer
    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, 32'(d));
    endtask : wr
    task automatic rdc(input logic [3:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 32'h0000_0000);
        chk(rd_q, 32'(exp));
    endtask : rdc
    task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
        wr(lo + 4'h1, v[15:8]);
        wr(lo, v[7:0]);
    endtask : wr16
    task automatic rd16(input logic [3:0] lo, input logic [15:0] v);
        rdc(lo, v[7:0]);
        rdc(lo + 4'h1, v[15:8]);
    endtask : rd16
    // Watches the capture flag over a fixed window and notes its latency.
    task automatic wait_cap(input logic exp);
        cap_lat = 0;
        for (int k = 1; k <= 24; k++)
        begin
            @(posedge clk_sys);
            if (cap_lat == 0 && tcc_link_if_i.cap_irq === 1'b1)
                cap_lat = k;
        end
        chk(32'(cap_lat != 0), 32'(exp));
    endtask : wait_cap
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        rst = 1'b1;
        {hwrite, capture_input_pin, comparator_output, ext_clk_pin} = 4'h0;
        {haddr, hwdata, htrans} = '0;
        hsize = 3'h2;
        hsel = 1'b1;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rdc(IDX_CTRL_B, 8'h00);
        rdc(IDX_FLAGS, 8'h00);
        rd16(IDX_CNT_LO, CNT_RST);
        rdc(4'hF, 8'h00);
        $display("test reset done");
        foreach (rows[i])
        begin
            wr16(IDX_CNT_LO, rows[i].val);
            rd16(IDX_CNT_LO, rows[i].val);
            chk(32'({at_top, at_bottom}), 32'({rows[i].top, rows[i].bot}));
        end
        $display("test table done");
        wr(IDX_CNT_HI, 8'h12);
        wr(IDX_CNT_LO, 8'h34);
        wr(IDX_CNT_LO, 8'h56);
        rd16(IDX_CNT_LO, 16'h1256);
        $display("test shared byte done");
        wr16(IDX_CNT_LO, 16'hFFFE);
        wr(IDX_IRQ_EN, 8'h01);
        wr(IDX_CTRL_B, 8'h01);
        for (int k = 0; k < 40 && irq !== 1'b1; k++)
            @(posedge clk_sys);
        chk(32'(irq), 32'h0000_0001);
        if (irq !== 1'b1)
            complete_run();
        wr16(IDX_CNT_LO, 16'h8000);
        wr(IDX_CTRL_B, 8'h00);
        chk(32'(count_value[15:8]), 32'h0000_0080);
        wr(IDX_LINK_CMD, 8'h01);
        rdc(IDX_FLAGS, 8'h00);
        chk(32'(irq), 32'h0000_0000);
        $display("test overflow done");
        wr(IDX_CTRL_B, 8'h40);
        wr16(IDX_CNT_LO, 16'h4321);
        wr(IDX_FLAGS, 8'h21);
        capture_input_pin <= 1'b1;
        wait_cap(1'b1);
        lat0 = cap_lat;
        wr(IDX_FLAGS, 8'h20);
        rdc(IDX_FLAGS, 8'h00);
        capture_input_pin <= 1'b0;
        wait_cap(1'b0);
        wr16(IDX_CNT_LO, 16'h0BCD);
        capture_input_pin <= 1'b1;
        wait_cap(1'b1);
        rd16(IDX_CAP_LO, 16'h0BCD);
        wr(IDX_IRQ_EN, 8'h20);
        @(posedge clk_sys);
        chk(32'(irq), 32'h0000_0001);
        wr(IDX_LINK_CMD, 8'h02);
        rdc(IDX_FLAGS, 8'h00);
        $display("test capture done");
        wr(IDX_CTRL_B, 8'hC0);
        capture_input_pin <= 1'b0;
        wait_cap(1'b0);
        capture_input_pin <= 1'b1;
        repeat (2) @(posedge clk_sys);
        capture_input_pin <= 1'b0;
        wait_cap(1'b0);
        capture_input_pin <= 1'b1;
        wait_cap(1'b1);
        chk(32'(cap_lat - lat0), 32'h0000_0004);
        $display("test filter done");
        wr(IDX_CMP_CTRL, 8'h04);
        wr(IDX_CTRL_B, 8'h40);
        wr(IDX_FLAGS, 8'h20);
        comparator_output <= 1'b1;
        wait_cap(1'b1);
        wr(IDX_CMP_CTRL, 8'h00);
        $display("test comparator done");
        wr(IDX_CTRL_B, 8'h18);
        wr(IDX_FLAGS, 8'h20);
        wr16(IDX_CAP_LO, 16'h2468);
        capture_input_pin <= 1'b0;
        wait_cap(1'b0);
        rd16(IDX_CAP_LO, 16'h2468);
        $display("test capture top done");
        complete_run();
    end
endmodule : timer16_counter_input_capture_tb
